/* src/tcc_channel2_cfg.sv */
// channel 2 capture/compare configuration, capture path and compare output, APB slave
// assumes counter, update event and trigger edge come from the timer core on mclk
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "tcc_cfg.svh"

// Functional notes
// RULE_01 - shadowed compare value loads on update
// RULE_02 - software enables shadow for PWM normally
// RULE_03 - fast enable: trigger edge acts as match
// RULE_04 - fast enable only in PWM modes
// RULE_05 - mode 00 selects output compare
// RULE_06 - modes 01..11 pick capture source
// RULE_07 - mode select writable only while disabled
// RULE_08 - trigger source needs internal trigger selected
// RULE_09 - filter needs run of samples; 0 bypasses
// RULE_10 - codes 1..3: kernel clock, 2/4/8
// RULE_11 - codes 4..15: divided dead-time clock rates
// RULE_12 - prescaler captures every 1/2/4/8 edges
// RULE_13 - edge counter cleared while channel disabled
// RULE_14 - ch2 filter 7:4, prescaler 3:2
// RULE_15 - ch3 filter 15:12, prescaler 11:10
// RULE_16 - run counter restarts on level change
module tcc_channel2_cfg
	import tcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic ch2Pin,
	input wire logic ch3Pin,
	input wire logic internal_trigger_signal,
	input wire logic triggerEdge,
	input wire logic updateEvent,
	input wire logic [15:0] counterValue,
	output logic ch2_output,
	output logic ch2CaptureEvent
);

	tcc_chan_t st_r;
	tcc_chan_t st_nxt;
	logic ch2_own_filtered_input;
	logic ch3_filtered_input_to_ch2;
	logic [1:0] ch2_mode_select;
	logic [1:0] ch3_mode_select;
	logic [3:0] ch2_capture_filter;
	logic [3:0] ch3_capture_filter;
	logic [1:0] ch2_capture_prescaler;
	logic [1:0] ch3_capture_prescaler;
	logic ch2_compare_shadow_en;
	logic ch2_compare_fast_en;
	logic [2:0] cmpMode;
	logic ch2_capture_source;
	logic srcRise;
	logic isPwm;
	logic match;
	logic below;
	logic access;
	logic wrStrobe;
	logic mapped;
	logic [15:0] wrMode;

	////////////////////////////////////////////////////////////////////////////
	// field views of the mode control word

	// RULE_14 channel 2 input layout
	assign ch2_capture_filter = st_r.modeCtl[`TCC_FLT2_LSB +: 4];
	assign ch2_capture_prescaler = st_r.modeCtl[`TCC_PSC2_LSB +: 2];
	assign ch2_mode_select = st_r.modeCtl[`TCC_MS2_LSB +: 2];
	// RULE_15 channel 3 input layout
	assign ch3_capture_filter = st_r.modeCtl[`TCC_FLT3_LSB +: 4];
	assign ch3_capture_prescaler = st_r.modeCtl[`TCC_PSC3_LSB +: 2];
	assign ch3_mode_select = st_r.modeCtl[`TCC_MS3_LSB +: 2];
	assign ch2_compare_shadow_en = st_r.modeCtl[`TCC_SEN2_BIT];
	assign ch2_compare_fast_en = st_r.modeCtl[`TCC_FEN2_BIT];
	assign cmpMode = st_r.modeCtl[`TCC_CMP2_LSB +: 3];

	////////////////////////////////////////////////////////////////////////////
	// input filters

	// RULE_09 filter on own input
	tcc_input_filter ch2Filter (
		.mclk(mclk),
		.rst(rst),
		.pinIn(ch2Pin),
		.filterCode(ch2_capture_filter),
		.filtered(ch2_own_filtered_input)
	);

	// neighbour input filtered by its own field
	tcc_input_filter ch3Filter (
		.mclk(mclk),
		.rst(rst),
		.pinIn(ch3Pin),
		.filterCode(ch3_capture_filter),
		.filtered(ch3_filtered_input_to_ch2)
	);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// edges needed per capture, minus one
	function automatic logic [2:0] edgeLimit(input logic [1:0] psc);
		edgeLimit = 3'((4'h1 << psc) - 4'h1);
	endfunction

	// value of the control word after a masked write
	function automatic logic [15:0] mergeMode(
		input logic [15:0] cur,
		input logic [15:0] wr,
		input logic en2,
		input logic en3
	);
		logic [15:0] res;
		res = wr;
		// RULE_07 mode select locked while enabled
		if (en2) begin
			res[`TCC_MS2_LSB +: 2] = cur[`TCC_MS2_LSB +: 2];
		end
		if (en3) begin
			res[`TCC_MS3_LSB +: 2] = cur[`TCC_MS3_LSB +: 2];
		end
		mergeMode = res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// capture source selection

	always_comb begin
		case (ch2_mode_select)
			// RULE_06 own filtered input
			`TCC_MS_OWN: ch2_capture_source = ch2_own_filtered_input;
			// RULE_06 neighbour filtered input
			`TCC_MS_NEIGHBOUR: ch2_capture_source = ch3_filtered_input_to_ch2;
			// RULE_08 trigger gated by selection
			`TCC_MS_TRIGGER: ch2_capture_source = internal_trigger_signal &&
				(st_r.internal_trigger_select_field != 4'h0);
			default: ch2_capture_source = 1'b0;
		endcase
	end

	assign srcRise = ch2_capture_source && !st_r.srcPrev;
	assign below = counterValue < st_r.ch2_compare_value;
	assign match = counterValue == st_r.ch2_compare_value;
	assign isPwm = (cmpMode == `TCC_CMP_PWM0) || (cmpMode == `TCC_CMP_PWM1);

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	assign access = psel && penable;
	assign wrStrobe = access && pwrite && st_r.pready;
	assign wrMode = mergeMode(st_r.modeCtl, pwdata[15:0], st_r.ch2_channel_enable,
		st_r.ch3ChannelEnable);

	always_comb begin
		if (paddr == `TCC_OFS_MODE_CTL) begin
			mapped = 1'b1;
		end else if (paddr == `TCC_OFS_CHAN_EN) begin
			mapped = 1'b1;
		end else if (paddr == `TCC_OFS_COMPARE) begin
			mapped = 1'b1;
		end else if (paddr == `TCC_OFS_CAPTURE) begin
			mapped = 1'b1;
		end else if (paddr == `TCC_OFS_STATUS) begin
			mapped = 1'b1;
		end else if (paddr == `TCC_OFS_TRIG_SEL) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.captureEvent = 1'b0;
		st_nxt.srcPrev = ch2_capture_source;

		// one wait state, answer on the second access cycle
		st_nxt.pready = access && !st_r.pready;
		if (access && !st_r.pready) begin
			st_nxt.pslverr = !mapped;
			st_nxt.prdata = 32'h0000_0000;
			if (!pwrite) begin
				if (paddr == `TCC_OFS_MODE_CTL) begin
					st_nxt.prdata = {16'h0000, st_r.modeCtl};
				end else if (paddr == `TCC_OFS_CHAN_EN) begin
					st_nxt.prdata[`TCC_EN2_BIT] = st_r.ch2_channel_enable;
					st_nxt.prdata[`TCC_EN3_BIT] = st_r.ch3ChannelEnable;
				end else if (paddr == `TCC_OFS_COMPARE) begin
					st_nxt.prdata = {16'h0000, st_r.ch2_compare_value};
				end else if (paddr == `TCC_OFS_CAPTURE) begin
					st_nxt.prdata = {16'h0000, st_r.captureValue};
				end else if (paddr == `TCC_OFS_STATUS) begin
					st_nxt.prdata = {25'h0000000, st_r.edgeCnt, 1'b0, st_r.ch2_output,
						ch3_filtered_input_to_ch2, ch2_own_filtered_input};
				end else if (paddr == `TCC_OFS_TRIG_SEL) begin
					st_nxt.prdata = {28'h0000000, st_r.internal_trigger_select_field};
				end
			end
		end else begin
			// error flag stands only beside pready
			st_nxt.pslverr = 1'b0;
		end

		// register writes land on the edge where pready is sampled high
		if (wrStrobe) begin
			if (paddr == `TCC_OFS_MODE_CTL) begin
				st_nxt.modeCtl = wrMode;
			end else if (paddr == `TCC_OFS_CHAN_EN) begin
				st_nxt.ch2_channel_enable = pwdata[`TCC_EN2_BIT];
				st_nxt.ch3ChannelEnable = pwdata[`TCC_EN3_BIT];
			end else if (paddr == `TCC_OFS_COMPARE) begin
				st_nxt.cvShadow = pwdata[15:0];
				// RULE_01 direct load without shadow
				if (!ch2_compare_shadow_en) begin
					st_nxt.ch2_compare_value = pwdata[15:0];
				end
			end else if (paddr == `TCC_OFS_TRIG_SEL) begin
				st_nxt.internal_trigger_select_field = pwdata[3:0];
			end
		end

		// RULE_01 shadow transfer on update
		if (updateEvent && ch2_compare_shadow_en) begin
			st_nxt.ch2_compare_value = st_r.cvShadow;
		end

		// capture path with edge prescaler
		if (!st_r.ch2_channel_enable) begin
			// RULE_13 counter held cleared
			st_nxt.edgeCnt = 3'h0;
		end else if (ch2_mode_select != `TCC_MS_OUTPUT && srcRise) begin
			// RULE_12 capture every 2^psc edges
			if (st_r.edgeCnt >= edgeLimit(ch2_capture_prescaler)) begin
				st_nxt.edgeCnt = 3'h0;
				st_nxt.captureEvent = 1'b1;
				st_nxt.captureValue = counterValue;
			end else begin
				st_nxt.edgeCnt = st_r.edgeCnt + 3'h1;
			end
		end

		// RULE_05 output compare only in mode 00
		if (ch2_mode_select != `TCC_MS_OUTPUT || !st_r.ch2_channel_enable) begin
			st_nxt.ch2_output = 1'b0;
		end else if (isPwm && ch2_compare_fast_en && triggerEdge) begin
			// RULE_03 RULE_04 trigger forces match level
			st_nxt.ch2_output = (cmpMode == `TCC_CMP_PWM1);
		end else begin
			case (cmpMode)
				`TCC_CMP_SET: begin
					if (match) begin
						st_nxt.ch2_output = 1'b1;
					end
				end
				`TCC_CMP_CLEAR: begin
					if (match) begin
						st_nxt.ch2_output = 1'b0;
					end
				end
				`TCC_CMP_TOGGLE: begin
					if (match) begin
						st_nxt.ch2_output = !st_r.ch2_output;
					end
				end
				`TCC_CMP_LOW: st_nxt.ch2_output = 1'b0;
				`TCC_CMP_HIGH: st_nxt.ch2_output = 1'b1;
				// up-counting only; direction belongs to the counter core
				`TCC_CMP_PWM0: st_nxt.ch2_output = below;
				`TCC_CMP_PWM1: st_nxt.ch2_output = !below;
				default: st_nxt.ch2_output = st_r.ch2_output;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.modeCtl <= `TCC_MODE_CTL_RST;
			st_r.cvShadow <= `TCC_COMPARE_RST;
			st_r.ch2_compare_value <= `TCC_COMPARE_RST;
			st_r.internal_trigger_select_field <= `TCC_TRIG_SEL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready = st_r.pready;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.pslverr;
	assign ch2_output = st_r.ch2_output;
	assign ch2CaptureEvent = st_r.captureEvent;

endmodule

/* src/tcc_cfg.svh */
// register offsets, field positions, reset values and filter timing for the channel 2 block
// assumes a 32-bit APB word map with byte addresses
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_OFS_MODE_CTL 8'h1C
`define TCC_OFS_CHAN_EN 8'h20
`define TCC_OFS_COMPARE 8'h3C
`define TCC_OFS_CAPTURE 8'h44
`define TCC_OFS_STATUS 8'h48
`define TCC_OFS_TRIG_SEL 8'h4C

// output compare layout of the mode control word
`define TCC_MS2_LSB 0
`define TCC_FEN2_BIT 2
`define TCC_SEN2_BIT 3
`define TCC_CMP2_LSB 4
`define TCC_MS3_LSB 8
// input capture layout of the mode control word
`define TCC_PSC2_LSB 2
`define TCC_FLT2_LSB 4
`define TCC_PSC3_LSB 10
`define TCC_FLT3_LSB 12
// enable word
`define TCC_EN2_BIT 8
`define TCC_EN3_BIT 12

`define TCC_MODE_CTL_RST 16'h0000
`define TCC_COMPARE_RST 16'h0000
`define TCC_TRIG_SEL_RST 4'h0

// mode select codes
`define TCC_MS_OUTPUT 2'h0
`define TCC_MS_OWN 2'h1
`define TCC_MS_NEIGHBOUR 2'h2
`define TCC_MS_TRIGGER 2'h3

// compare output modes
`define TCC_CMP_TIMING 3'h0
`define TCC_CMP_SET 3'h1
`define TCC_CMP_CLEAR 3'h2
`define TCC_CMP_TOGGLE 3'h3
`define TCC_CMP_LOW 3'h4
`define TCC_CMP_HIGH 3'h5
`define TCC_CMP_PWM0 3'h6
`define TCC_CMP_PWM1 3'h7

// filter sample divider width, log2 of the largest dead-time division
`define TCC_DIV_W 5

`endif

/* src/tcc_pkg.sv */
// state types of the channel 2 capture/compare block
// assumes tcc_cfg.svh for all numbers
package tcc_pkg;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic agreed;
		logic prevSample;
		logic [3:0] runCnt;
		logic [4:0] divCnt;
		logic level;
	} tcc_filter_t;

	typedef struct packed {
		logic [15:0] modeCtl;
		logic ch2_channel_enable;
		logic ch3ChannelEnable;
		logic [3:0] internal_trigger_select_field;
		logic [15:0] cvShadow;
		logic [15:0] ch2_compare_value;
		logic [15:0] captureValue;
		logic [2:0] edgeCnt;
		logic srcPrev;
		logic ch2_output;
		logic captureEvent;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tcc_chan_t;

endpackage

/* src/tcc_input_filter.sv */
// three-flop synchroniser and digital noise filter for one capture input
// assumes pin is asynchronous to mclk; dead-time clock equals mclk
`timescale 1ns/1ns
`include "tcc_cfg.svh"

module tcc_input_filter
	import tcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic pinIn,
	input wire logic [3:0] filterCode,
	output logic filtered
);

	tcc_filter_t st_r;
	tcc_filter_t st_nxt;
	logic [2:0] divLog;
	logic [3:0] need;
	logic tick;

	// sample rate as log2 of the divider
	function automatic logic [2:0] rateLog(input logic [3:0] c);
		if (c < 4'h4) begin
			rateLog = 3'h0;
		end else if (c < 4'hA) begin
			rateLog = 3'(({1'b0, c} - 5'h2) >> 1);
		end else if (c < 4'hD) begin
			rateLog = 3'h4;
		end else begin
			rateLog = 3'h5;
		end
	endfunction

	function automatic logic [3:0] runNeed(input logic [3:0] c);
		case (c)
			4'h1: runNeed = 4'h2;
			4'h2: runNeed = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hB, 4'hE: runNeed = 4'h6;
			4'hA, 4'hD: runNeed = 4'h5;
			default: runNeed = 4'h8;
		endcase
	endfunction

	always_comb begin
		st_nxt = st_r;
		divLog = rateLog(filterCode);
		need = runNeed(filterCode);
		tick = ((st_r.divCnt & 5'((6'h01 << divLog) - 6'h01)) == 5'h00);
		st_nxt.s1 = pinIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.agreed = st_r.s3;
		end
		st_nxt.divCnt = st_r.divCnt + 5'h01;
		// RULE_09 code zero bypass
		if (filterCode == 4'h0) begin
			st_nxt.level = st_r.agreed;
			st_nxt.runCnt = 4'h0;
		end else if (tick) begin
			st_nxt.prevSample = st_r.agreed;
			// RULE_16 restart on change
			if (st_r.agreed != st_r.prevSample) begin
				st_nxt.runCnt = 4'h0;
			end else if (st_r.runCnt < 4'hF) begin
				st_nxt.runCnt = st_r.runCnt + 4'h1;
			end
			// RULE_10 RULE_11 run length met
			if (st_r.agreed == st_r.prevSample && ({1'b0, st_r.runCnt} + 5'h02) >= {1'b0, need}) begin
				st_nxt.level = st_r.agreed;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign filtered = st_r.level;

endmodule

/* verif/tcc_channel2_cfg_assertions.sv */
// port checker for the channel 2 capture/compare block
// assumes it is bound to tcc_channel2_cfg and sees its ports only
`timescale 1ns/1ns
module tcc_channel2_cfg_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic ch2_output,
	input wire logic ch2CaptureEvent
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sequence sSetup;
		psel && !penable;
	endsequence
	sequence sAccess;
		psel && penable && !pready;
	endsequence
	AST_APB_WAIT: assert property (sSetup ##1 sAccess |=> pready)
		else $error("ready missing after one wait state");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("ready outside an access");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	AST_ERR_MAP: assert property (pready |-> pslverr == !(paddr inside {8'h1C, 8'h20, 8'h3C, 8'h44, 8'h48, 8'h4C}))
		else $error("error response does not match the map");
	AST_PRDATA_HOLD: assert property (!(psel && penable) |=> $stable(prdata))
		else $error("read data moved between accesses");
	AST_CAP_NOT_OUT: assert property (ch2CaptureEvent |-> !ch2_output)
		else $error("capture while output compare drives");
	AST_CAP_PULSE: assert property (ch2CaptureEvent |=> !ch2CaptureEvent)
		else $error("capture event longer than one cycle");
endmodule

bind tcc_channel2_cfg tcc_channel2_cfg_chk u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch2_output(ch2_output),
	.ch2CaptureEvent(ch2CaptureEvent));

/* verif/tcc_pin_model.sv */
// model of the capture pins and the internal trigger source
// assumes go is a one-cycle request; idle lines sit low
`timescale 1ns/1ns
module tcc_pin_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [1:0] src,
	input wire logic [15:0] len,
	output logic ch2Pin,
	output logic ch3Pin,
	output logic internal_trigger_signal,
	output logic busy
);
	logic [15:0] cnt;
	logic [1:0] sel;
	initial begin
		cnt = 16'h0000;
		sel = 2'h0;
	end
	// one line high for len cycles, the others quiet
	always @(posedge mclk) begin
		if (go) begin
			cnt <= len;
			sel <= src;
		end else if (cnt != 16'h0000)
			cnt <= cnt - 16'h0001;
	end
	assign busy = go || cnt != 16'h0000;
	assign ch2Pin = cnt != 16'h0000 && sel == 2'h1;
	assign ch3Pin = cnt != 16'h0000 && sel == 2'h2;
	assign internal_trigger_signal = cnt != 16'h0000 && sel == 2'h3;
endmodule

/* verif/tcc_channel2_cfg_tb.sv */
// self-checking bench for the channel 2 capture/compare block
// assumes the pin model drives the capture inputs, bench plays timer core
`timescale 1ns/1ns
module tcc_channel2_cfg_tb;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic triggerEdge, updateEvent, ch2_output, capEv, go, busy;
	logic ch2Pin, ch3Pin, internal_trigger_signal;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, nCap, b;
	logic [15:0] counterValue, len, cv, prevCv, r;
	logic [1:0] src;
	int failures, n_compared, seed, c, m, s;
	tcc_channel2_cfg dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ch2Pin(ch2Pin), .ch3Pin(ch3Pin), .internal_trigger_signal(internal_trigger_signal),
		.triggerEdge(triggerEdge), .updateEvent(updateEvent), .counterValue(counterValue),
		.ch2_output(ch2_output), .ch2CaptureEvent(capEv));
	tcc_pin_model pins (.mclk(mclk), .go(go), .src(src), .len(len), .ch2Pin(ch2Pin), .ch3Pin(ch3Pin),
		.internal_trigger_signal(internal_trigger_signal), .busy(busy));
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk or posedge rst) begin
		if (rst)
			nCap <= 32'h0;
		else if (capEv)
			nCap <= nCap + 32'h1;
	end
	////////////////////////////////////////////////////////////////
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			failures++;
			conclude;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task pulse(input logic [1:0] sc, input int w, input int gap);
		int i;
		go <= 1;
		src <= sc;
		len <= 16'(w);
		@(posedge mclk);
		go <= 0;
		i = 0;
		while (busy && i < 600) begin
			@(posedge mclk);
			i++;
		end
		if (busy) begin
			failures++;
			conclude;
		end
		repeat (gap) @(posedge mclk);
	endtask
	function automatic logic [31:0] mk(input logic [3:0] f2, input logic [1:0] p2, input logic [3:0] f3,
		input logic [1:0] p3, input logic [1:0] md);
		return {16'h0, f3, p3, 2'h0, f2, p2, md};
	endfunction
	// filter window in mclk cycles: samples times divider
	function automatic int span(input int k);
		int d;
		int n;
		d = k < 4 ? 1 : k < 10 ? 2 << ((k - 4) / 2) : k < 13 ? 16 : 32;
		n = k == 0 ? 1 : k < 4 ? 2 << (k - 1) : k < 10 ? 6 + 2 * (k % 2) : (k == 10 || k == 13) ? 5 :
			(k == 11 || k == 14) ? 6 : 8;
		return n * d;
	endfunction
	task setup(input logic [1:0] md, input logic [3:0] f, input logic [1:0] p);
		apb(1, 8'h20, 32'h0);
		apb(1, 8'h1C, mk(f, p, 4'h0, 2'h0, md));
		apb(1, 8'h20, 32'h100);
	endtask
	// output seen in the cycle after the trigger edge, then once more
	task trig(input int exp, input int after);
		triggerEdge <= 1;
		@(posedge mclk);
		triggerEdge <= 0;
		@(posedge mclk);
		chk({31'h0, ch2_output}, 32'(exp));
		@(posedge mclk);
		chk({31'h0, ch2_output}, 32'(after));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 10;
		failures = 0;
		n_compared = 0;
		{psel, penable, pwrite, go, triggerEdge, updateEvent} = 6'h00;
		{paddr, pwdata, counterValue, len, src} = '0;
		rst = 1;
		repeat (5) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		apb(0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		apb(0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (c = 0; c < 4; c++) begin
			b = 32'($random(seed)) & 32'hFCFC;
			apb(1, 8'h1C, b);
			apb(0, 8'h1C, 32'h0);
			chk(rd, b);
		end
		setup(2'h1, 4'h0, 2'h0);
		apb(1, 8'h1C, mk(4'h5, 2'h2, 4'h0, 2'h0, 2'h0));
		apb(0, 8'h1C, 32'h0);
		chk(rd, mk(4'h5, 2'h2, 4'h0, 2'h0, 2'h1));
		for (c = 0; c < 16; c++) begin
			setup(2'h1, 4'(c), 2'h0);
			b = nCap;
			// a pulse of half the filter window is rejected; with code 0 a two-cycle pulse passes
			pulse(2'h1, c == 0 ? 2 : (span(c) + 1) / 2, 2 * span(c) + 20);
			chk(nCap - b, 32'(c == 0));
			pulse(2'h1, 2 * span(c) + 8, 2 * span(c) + 20);
			chk(nCap - b, 32'(c == 0) + 32'h1);
		end
		for (c = 0; c < 4; c++) begin
			setup(2'h1, 4'h0, 2'(c));
			b = nCap;
			repeat (8) pulse(2'h1, 3, 6);
			chk(nCap - b, 32'h8 >> c);
		end
		setup(2'h1, 4'h0, 2'h3);
		repeat (5) pulse(2'h1, 3, 6);
		apb(1, 8'h20, 32'h0);
		apb(1, 8'h20, 32'h100);
		b = nCap;
		repeat (4) pulse(2'h1, 3, 6);
		chk(nCap - b, 32'h0);
		for (c = 0; c < 2; c++) begin
			apb(1, 8'h4C, 32'(c));
			for (m = 1; m < 4; m++) begin
				for (s = 1; s < 4; s++) begin
					setup(2'(m), 4'h0, 2'h0);
					b = nCap;
					pulse(2'(s), 3, 8);
					chk(nCap - b, 32'(m == s && (m != 3 || c == 1)));
				end
			end
		end
		setup(2'h0, 4'h0, 2'h0);
		apb(1, 8'h1C, 32'h68);
		prevCv = 16'h0;
		for (c = 0; c < 6; c++) begin
			cv = 16'($random(seed));
			r = c == 0 ? cv : 16'($random(seed));
			counterValue <= r;
			apb(1, 8'h3C, {16'h0, cv});
			apb(0, 8'h3C, 32'h0);
			chk(rd, {16'h0, prevCv});
			chk({31'h0, ch2_output}, 32'(r < prevCv));
			updateEvent <= 1;
			@(posedge mclk);
			updateEvent <= 0;
			repeat (3) @(posedge mclk);
			chk({31'h0, ch2_output}, 32'(r < cv));
			prevCv = cv;
		end
		apb(1, 8'h3C, 32'h8000);
		updateEvent <= 1;
		counterValue <= 16'h0;
		@(posedge mclk);
		updateEvent <= 0;
		apb(1, 8'h1C, 32'h7C);
		trig(1, 0);
		apb(1, 8'h1C, 32'h78);
		trig(0, 0);
		apb(1, 8'h1C, 32'h6C);
		trig(0, 1);
		apb(1, 8'h1C, 32'h5C);
		trig(1, 1);
		conclude;
	end
endmodule
